// >>> logic/rac_regs.svh
// Register offsets, bit positions and power-up values for the audio control bank.
// Assumes byte-wide registers reached through the two-wire serial slave.
`ifndef RAC_REGS_SVH
`define RAC_REGS_SVH

// Slave address is arbitrary, not tied to any part
`define RAC_DEV_ADDR      7'h2A

`define RAC_OFF_CAL       8'h07
`define RAC_OFF_AUDIO     8'h08
`define RAC_OFF_CHG       8'h09
`define RAC_OFF_STAT      8'h0A

// Calibration and pin control register
`define RAC_CAL_SIGN_BIT  5
`define RAC_FT_BIT        6
`define RAC_OUT_BIT       7
// Audio control register
`define RAC_MUTE_BIT      4
`define RAC_TONE_EN_BIT   5
`define RAC_TONE_512_BIT  6
// Trickle charge register
`define RAC_CHG_SW_BIT    4
`define RAC_OSC_FAIL_IRQ_EN_BIT      5
`define RAC_BYPASS_BIT    6
// Status register
`define RAC_OF_BIT        2
`define RAC_HT_BIT        6
`define RAC_ST_BIT        7

`define RAC_KEY_SAFE      4'hA
`define RAC_KEY_CLOSE     4'h5
`define RAC_GAIN_FIRST    4'h0
`define RAC_CAL_FIRST     5'h00

// Gain in dB, two's complement: code 0 is -33, 3 dB per step
`define RAC_GAIN_DB_MIN   7'h5F
`define RAC_GAIN_DB_STEP  7'h03

`define RAC_BYTE_BITS     4'h8

`endif

// >>> logic/rac_pkg.sv
// Types shared by the audio control bank.
// Assumes rac_regs.svh supplies all offsets and values.
package rac_pkg;

    typedef enum logic [3:0] {
        RAC_IDLE,
        RAC_ADDR,
        RAC_ADDR_ACK,
        RAC_PTR,
        RAC_PTR_ACK,
        RAC_WDATA,
        RAC_WDATA_ACK,
        RAC_RDATA,
        RAC_RACK
    } rac_state_t;

    typedef struct packed {
        logic       osc_disable;
        logic       update_freeze;
        logic       out_level;
        logic       freq_test_enable;
        logic       osc_fail_flag;
        logic       osc_fail_irq_en;
        logic [3:0] charge_key_field;
        logic       charge_switch_en;
        logic       diode_bypass_en;
        logic       tone_512;
        logic       tone_en;
        logic       mute;
        logic [3:0] gain;
        logic       cal_sign;
        logic [4:0] cal;
    } rac_regs_t;

    typedef struct packed {
        rac_state_t st;
        logic [3:0] bitcnt;
        logic [7:0] shift;
        logic [7:0] ptr;
        logic       rw;
        logic       more;
        logic       scl_d;
        logic       sda_d;
        logic       vcc_d;
        logic       powered;
        logic       sda_oe;
        logic       mfp_oe;
        logic       audio_on;
        logic       charge_path;
        logic [6:0] gain_db;
        rac_regs_t  regs;
    } rac_core_t;

endpackage

// >>> logic/rac_sync.sv
// Two-flop synchroniser for a group of asynchronous inputs.
// Assumes the inputs are independent levels; no bus coherency is implied.
`timescale 1ns/10ps
module rac_sync #(
    parameter int W = 1
) (
    input  wire logic         sys_clk_i,
    input  wire logic         reset_n_i,
    input  wire logic         ce_i,
    input  wire logic [W-1:0] async_i,
    output logic      [W-1:0] sync_o
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } rac_sync_st_t;

    rac_sync_st_t q_reg;
    rac_sync_st_t q_next;

    always_comb begin
        q_next    = q_reg;
        q_next.s1 = async_i;
        q_next.s2 = q_reg.s1;
    end

    always_ff @(posedge sys_clk_i) begin
        if (!reset_n_i) begin
            q_reg <= '0;
        end else if (ce_i) begin
            q_reg <= q_next;
        end
    end

    assign sync_o = q_reg.s2;
endmodule

// >>> logic/rac_audio_ctl.sv
// Audio control and power-up initial values of a serial clock, behind a two-wire slave.
// Assumes scl/sda, supply-good and oscillator-stop pins are asynchronous.
//
// Operation
// - Beep enable swaps amplifier output for tone
// - Volume code is bits 3..0 at 08h
// - Gain runs -33 to +12 dB, 3 dB steps
// - Silence bit turns audio fully off
// - First power-up: volume 0, silence set
// - Later power-up: keep volume, force silence
// - Oscillator disable 0 first, then kept
// - Update freeze set every power-up
// - Pin level 1 first, then kept
// - Frequency test cleared every power-up
// - Oscillator fail set first, then kept
// - Charge switch and bypass cleared always
// - Charge key loaded with A always
// - First power-up: 512 Hz, beep off
// - Later power-up: keep tone, beep off
// - Calibration and sign cleared first, then kept
`timescale 1ns/10ps
`include "rac_regs.svh"
module rac_audio_ctl (
    input  wire logic       sys_clk_i,
    input  wire logic       reset_n_i,
    input  wire logic       ce_i,
    input  wire logic       scl_i,
    input  wire logic       sda_i,
    input  wire logic       vcc_good_i,
    input  wire logic       osc_stopped_i,
    output logic            sda_o,
    output logic            sda_oe_o,
    output logic            mfp_o,
    output logic            mfp_oe_o,
    output logic            audio_on_o,
    output logic            tone_insert_o,
    output logic            tone_512_o,
    output logic [3:0]      gain_code_o,
    output logic [6:0]      gain_db_o,
    output logic            osc_disable_o,
    output logic            update_freeze_o,
    output logic            freq_test_o,
    output logic            osc_fail_o,
    output logic            charge_path_o,
    output logic            diode_bypass_o
);
    ////////////////////////////////////////////////////////////////////////////
    rac_pkg::rac_core_t q_reg;
    rac_pkg::rac_core_t q_next;
    logic [3:0]         pins_s;
    logic               scl_s;
    logic               sda_s;
    logic               vcc_s;
    logic               osc_s;
    logic               scl_rise;
    logic               scl_fall;
    logic               bus_start;
    logic               bus_stop;
    logic               pwr_rise;
    logic               wr_fire;
    logic [7:0]         wr_data;

    rac_sync #(
        .W (4)
    ) u_sync (
        .sys_clk_i (sys_clk_i),
        .reset_n_i (reset_n_i),
        .ce_i      (ce_i),
        .async_i   ({osc_stopped_i, vcc_good_i, sda_i, scl_i}),
        .sync_o    (pins_s)
    );

    assign scl_s = pins_s[0];
    assign sda_s = pins_s[1];
    assign vcc_s = pins_s[2];
    assign osc_s = pins_s[3];

    ////////////////////////////////////////////////////////////////////////////
    function automatic rac_pkg::rac_regs_t first_regs();
        rac_pkg::rac_regs_t r;
        r                  = '0;
        r.osc_disable      = 1'b0;
        r.update_freeze    = 1'b1;
        r.out_level        = 1'b1;
        r.osc_fail_flag    = 1'b1;
        r.charge_key_field = `RAC_KEY_SAFE;
        r.tone_512         = 1'b1;
        r.mute             = 1'b1;
        r.gain             = `RAC_GAIN_FIRST;
        r.cal              = `RAC_CAL_FIRST;
        r.cal_sign         = 1'b0;
        return r;
    endfunction

    // Later power-ups keep everything backup held except the forced bits
    function automatic rac_pkg::rac_regs_t powerup_regs(input rac_pkg::rac_regs_t cur,
                                                        input logic first);
        rac_pkg::rac_regs_t r;
        r                  = first ? first_regs() : cur;
        r.update_freeze    = 1'b1;
        r.freq_test_enable = 1'b0;
        r.charge_switch_en = 1'b0;
        r.diode_bypass_en  = 1'b0;
        r.charge_key_field = `RAC_KEY_SAFE;
        r.tone_en          = 1'b0;
        r.mute             = 1'b1;
        return r;
    endfunction

    function automatic logic [7:0] read_byte(input rac_pkg::rac_regs_t r,
                                             input logic [7:0] a);
        logic [7:0] v;
        v = 8'h00;
        unique case (a)
            `RAC_OFF_CAL: begin
                v[4:0]                = r.cal;
                v[`RAC_CAL_SIGN_BIT]  = r.cal_sign;
                v[`RAC_FT_BIT]        = r.freq_test_enable;
                v[`RAC_OUT_BIT]       = r.out_level;
            end
            `RAC_OFF_AUDIO: begin
                v[3:0]                = r.gain;
                v[`RAC_MUTE_BIT]      = r.mute;
                v[`RAC_TONE_EN_BIT]   = r.tone_en;
                v[`RAC_TONE_512_BIT]  = r.tone_512;
            end
            `RAC_OFF_CHG: begin
                v[3:0]                = r.charge_key_field;
                v[`RAC_CHG_SW_BIT]    = r.charge_switch_en;
                v[`RAC_OSC_FAIL_IRQ_EN_BIT]      = r.osc_fail_irq_en;
                v[`RAC_BYPASS_BIT]    = r.diode_bypass_en;
            end
            `RAC_OFF_STAT: begin
                v[`RAC_OF_BIT]        = r.osc_fail_flag;
                v[`RAC_HT_BIT]        = r.update_freeze;
                v[`RAC_ST_BIT]        = r.osc_disable;
            end
            default: v = 8'h00;
        endcase
        return v;
    endfunction

    function automatic rac_pkg::rac_regs_t write_byte(input rac_pkg::rac_regs_t cur,
                                                      input logic [7:0] a,
                                                      input logic [7:0] v);
        rac_pkg::rac_regs_t r;
        r = cur;
        unique case (a)
            `RAC_OFF_CAL: begin
                r.cal              = v[4:0];
                r.cal_sign         = v[`RAC_CAL_SIGN_BIT];
                r.freq_test_enable = v[`RAC_FT_BIT];
                r.out_level        = v[`RAC_OUT_BIT];
            end
            `RAC_OFF_AUDIO: begin
                r.gain             = v[3:0];
                r.mute             = v[`RAC_MUTE_BIT];
                r.tone_en          = v[`RAC_TONE_EN_BIT];
                r.tone_512         = v[`RAC_TONE_512_BIT];
            end
            `RAC_OFF_CHG: begin
                r.charge_key_field = v[3:0];
                r.charge_switch_en = v[`RAC_CHG_SW_BIT];
                r.osc_fail_irq_en  = v[`RAC_OSC_FAIL_IRQ_EN_BIT];
                r.diode_bypass_en  = v[`RAC_BYPASS_BIT];
            end
            `RAC_OFF_STAT: begin
                // Fail flag can only be cleared by software
                r.osc_fail_flag    = cur.osc_fail_flag & v[`RAC_OF_BIT];
                r.update_freeze    = v[`RAC_HT_BIT];
                r.osc_disable      = v[`RAC_ST_BIT];
            end
            default: r = cur;
        endcase
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    assign scl_rise  = scl_s & ~q_reg.scl_d;
    assign scl_fall  = ~scl_s & q_reg.scl_d;
    assign bus_start = scl_s & q_reg.scl_d & q_reg.sda_d & ~sda_s;
    assign bus_stop  = scl_s & q_reg.scl_d & ~q_reg.sda_d & sda_s;
    assign pwr_rise  = vcc_s & ~q_reg.vcc_d;

    always_comb begin
        q_next       = q_reg;
        wr_fire      = 1'b0;
        wr_data      = q_reg.shift;
        q_next.scl_d = scl_s;
        q_next.sda_d = sda_s;
        q_next.vcc_d = vcc_s;

        // Serial slave; held idle while the supply is down
        if (!vcc_s || bus_stop) begin
            q_next.st     = rac_pkg::RAC_IDLE;
            q_next.sda_oe = 1'b0;
        end else if (bus_start) begin
            q_next.st     = rac_pkg::RAC_ADDR;
            q_next.bitcnt = 4'h0;
            q_next.sda_oe = 1'b0;
        end else begin
            unique case (q_reg.st)
                rac_pkg::RAC_IDLE: begin
                    q_next.sda_oe = 1'b0;
                end
                rac_pkg::RAC_ADDR, rac_pkg::RAC_PTR, rac_pkg::RAC_WDATA: begin
                    if (scl_rise) begin
                        q_next.shift  = {q_reg.shift[6:0], sda_s};
                        q_next.bitcnt = q_reg.bitcnt + 4'h1;
                    end else if (scl_fall && q_reg.bitcnt == `RAC_BYTE_BITS) begin
                        q_next.sda_oe = 1'b1;
                        if (q_reg.st == rac_pkg::RAC_ADDR) begin
                            if (q_reg.shift[7:1] == `RAC_DEV_ADDR) begin
                                q_next.rw = q_reg.shift[0];
                                q_next.st = rac_pkg::RAC_ADDR_ACK;
                            end else begin
                                q_next.sda_oe = 1'b0;
                                q_next.st     = rac_pkg::RAC_IDLE;
                            end
                        end else if (q_reg.st == rac_pkg::RAC_PTR) begin
                            q_next.ptr = q_reg.shift;
                            q_next.st  = rac_pkg::RAC_PTR_ACK;
                        end else begin
                            wr_fire     = 1'b1;
                            q_next.regs = write_byte(q_reg.regs, q_reg.ptr, q_reg.shift);
                            q_next.ptr  = q_reg.ptr + 8'h01;
                            q_next.st   = rac_pkg::RAC_WDATA_ACK;
                        end
                    end
                end
                rac_pkg::RAC_ADDR_ACK, rac_pkg::RAC_PTR_ACK, rac_pkg::RAC_WDATA_ACK: begin
                    if (scl_fall) begin
                        q_next.bitcnt = 4'h0;
                        q_next.sda_oe = 1'b0;
                        if (q_reg.st == rac_pkg::RAC_ADDR_ACK && q_reg.rw) begin
                            q_next.shift  = read_byte(q_reg.regs, q_reg.ptr);
                            q_next.ptr    = q_reg.ptr + 8'h01;
                            q_next.sda_oe = ~q_next.shift[7];
                            q_next.st     = rac_pkg::RAC_RDATA;
                        end else if (q_reg.st == rac_pkg::RAC_ADDR_ACK) begin
                            q_next.st = rac_pkg::RAC_PTR;
                        end else begin
                            q_next.st = rac_pkg::RAC_WDATA;
                        end
                    end
                end
                rac_pkg::RAC_RDATA: begin
                    if (scl_rise) begin
                        q_next.bitcnt = q_reg.bitcnt + 4'h1;
                    end else if (scl_fall) begin
                        if (q_reg.bitcnt == `RAC_BYTE_BITS) begin
                            q_next.sda_oe = 1'b0;
                            q_next.st     = rac_pkg::RAC_RACK;
                        end else begin
                            q_next.sda_oe = ~q_reg.shift[3'(4'h7 - q_reg.bitcnt)];
                        end
                    end
                end
                rac_pkg::RAC_RACK: begin
                    if (scl_rise) begin
                        q_next.more = ~sda_s;
                    end else if (scl_fall) begin
                        q_next.bitcnt = 4'h0;
                        if (q_reg.more) begin
                            q_next.shift  = read_byte(q_reg.regs, q_reg.ptr);
                            q_next.ptr    = q_reg.ptr + 8'h01;
                            q_next.sda_oe = ~q_next.shift[7];
                            q_next.st     = rac_pkg::RAC_RDATA;
                        end else begin
                            q_next.st = rac_pkg::RAC_IDLE;
                        end
                    end
                end
            endcase
        end

        // Power-up set overrides any bus write of the same cycle; it starts from the old registers, so that write is lost
        if (pwr_rise) begin
            q_next.regs    = powerup_regs(q_reg.regs, ~q_reg.powered);
            q_next.powered = 1'b1;
        end

        // Set wins over a software clear in the same cycle
        if (osc_s) begin
            q_next.regs.osc_fail_flag = 1'b1;
        end

        q_next.audio_on    = vcc_s & ~q_reg.regs.mute;
        q_next.mfp_oe      = ~q_reg.regs.out_level;
        q_next.charge_path = q_reg.regs.charge_switch_en
                             & (q_reg.regs.charge_key_field == `RAC_KEY_CLOSE);
        q_next.gain_db     = `RAC_GAIN_DB_MIN
                             + ({3'h0, q_reg.regs.gain} * `RAC_GAIN_DB_STEP);
    end

    always_ff @(posedge sys_clk_i) begin
        if (!reset_n_i) begin
            q_reg         <= '0;
            q_reg.regs    <= first_regs();
            q_reg.gain_db <= `RAC_GAIN_DB_MIN;
        end else if (ce_i) begin
            q_reg <= q_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    assign sda_o           = 1'b0;
    assign sda_oe_o        = q_reg.sda_oe;
    assign mfp_o           = 1'b0;
    assign mfp_oe_o        = q_reg.mfp_oe;
    assign audio_on_o      = q_reg.audio_on;
    assign tone_insert_o   = q_reg.regs.tone_en;
    assign tone_512_o      = q_reg.regs.tone_512;
    assign gain_code_o     = q_reg.regs.gain;
    assign gain_db_o       = q_reg.gain_db;
    assign osc_disable_o   = q_reg.regs.osc_disable;
    assign update_freeze_o = q_reg.regs.update_freeze;
    assign freq_test_o     = q_reg.regs.freq_test_enable;
    assign osc_fail_o      = q_reg.regs.osc_fail_flag;
    assign charge_path_o   = q_reg.charge_path;
    assign diode_bypass_o  = q_reg.regs.diode_bypass_en;

    ////////////////////////////////////////////////////////////////////////////
    chk_mute_kills_audio: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        (ce_i && q_reg.regs.mute) |=> !audio_on_o)
        else $error("audio on while silenced");

    chk_gain_db_map: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        ce_i |=> gain_db_o == 7'(`RAC_GAIN_DB_MIN + {3'h0, $past(q_reg.regs.gain)} * 7'h03))
        else $error("gain dB does not follow code");

    chk_gain_write: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        (ce_i && wr_fire && q_reg.ptr == `RAC_OFF_AUDIO && !pwr_rise)
        |=> gain_code_o == $past(wr_data[3:0]) && tone_insert_o == $past(wr_data[5]))
        else $error("audio write not taken");

    chk_powerup_forced: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        (ce_i && pwr_rise) |=> update_freeze_o && !freq_test_o && !tone_insert_o
        && q_reg.regs.mute && !diode_bypass_o && q_reg.regs.charge_key_field == 4'hA)
        else $error("forced power-up bits wrong");

    chk_first_values: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        (ce_i && pwr_rise && !q_reg.powered) |=> gain_code_o == 4'h0 && !osc_disable_o
        && osc_fail_o && tone_512_o && q_reg.regs.cal == 5'h00 ##1 !audio_on_o && !mfp_oe_o)
        else $error("first power-up values wrong");

    chk_later_keeps: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        (ce_i && pwr_rise && q_reg.powered && !osc_s) |=> gain_code_o == $past(gain_code_o)
        && tone_512_o == $past(tone_512_o) && osc_fail_o == $past(osc_fail_o)
        && osc_disable_o == $past(osc_disable_o))
        else $error("later power-up lost retained bits");

    chk_osc_fail_sets: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        (ce_i && osc_s) |=> osc_fail_o)
        else $error("oscillator fail not flagged");

    chk_charge_key: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        (ce_i && q_reg.regs.charge_key_field != 4'h5) |=> !charge_path_o)
        else $error("charge path closed without key");

endmodule

// >>> testbench/rac_host_model.sv
// Two-wire bus master model for the audio control bank.
// Assumes a pull-up on SDA; sda_i is the resolved wire level.
`timescale 1ns/10ps
`include "rac_regs.svh"
module rac_host_model (
    input  wire logic clk_i,
    input  wire logic sda_i,
    output logic      scl_o,
    output logic      sda_oe_o
);
    initial begin
        scl_o = 1'b1;
        sda_oe_o = 1'b0;
    end
    ////////////////////////////////////////
    // Four cycles a phase, above the three the slave needs
    task automatic ph();
        repeat (4) @(negedge clk_i);
    endtask
    task automatic bit_x(input logic b, output logic r);
        sda_oe_o = ~b;
        ph();
        scl_o = 1'b1;
        ph();
        r = sda_i;
        scl_o = 1'b0;
    endtask
    // Ninth bit released: ACK from slave, or NACK that ends a read
    task automatic byte_x(input logic [7:0] d, output logic [7:0] q, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_x(d[i], r);
            q[i] = r;
        end
        bit_x(1'b1, r);
        ack = ~r;
    endtask
    // Low phase first, so a held ACK is gone before SCL rises
    task automatic start();
        sda_oe_o = 1'b0;
        ph();
        scl_o = 1'b1;
        ph();
        sda_oe_o = 1'b1;
        ph();
        scl_o = 1'b0;
    endtask
    task automatic stop();
        sda_oe_o = 1'b1;
        ph();
        scl_o = 1'b1;
        ph();
        sda_oe_o = 1'b0;
        ph();
    endtask
    ////////////////////////////////////////
    task automatic wr(input logic [6:0] ad, input logic [7:0] p, d, output logic [2:0] a);
        logic [7:0] q;
        start();
        byte_x({ad, 1'b0}, q, a[2]);
        byte_x(p, q, a[1]);
        byte_x(d, q, a[0]);
        stop();
    endtask
    task automatic rd(input logic [7:0] p, output logic [7:0] q);
        logic a;
        start();
        byte_x({`RAC_DEV_ADDR, 1'b0}, q, a);
        byte_x(p, q, a);
        start();
        byte_x({`RAC_DEV_ADDR, 1'b1}, q, a);
        byte_x(8'hFF, q, a);
        stop();
    endtask
endmodule

// >>> testbench/rac_audio_ctl_test.sv
// Self-checking bench for the audio control bank.
// Assumes rac_host_model as bus master and a pull-up on SDA.
`timescale 1ns/10ps
`include "rac_regs.svh"
module rac_audio_ctl_test;
    logic        sys_clk_i = 1'b0;
    logic        reset_n_i = 1'b0;
    logic        vcc_i     = 1'b0;
    logic        osc_i     = 1'b0;
    logic        ce        = 1'b1;
    logic        scl, h_oe, s_oe, sda, od, hf, mo, ft, of, cp, db, t5, ti, ao;
    logic [3:0]  gc;
    logic [6:0]  gd;
    logic [20:0] st;
    logic [7:0]  q;
    logic [2:0]  a;
    int          fail_count = 0;
    int          n_tests    = 0;
    always #25 sys_clk_i = ~sys_clk_i;
    assign sda = ~(h_oe | s_oe);
    assign st = {od, hf, mo, ft, of, cp, db, t5, ti, ao, gc, gd};
    rac_host_model host (.clk_i(sys_clk_i), .sda_i(sda), .scl_o(scl), .sda_oe_o(h_oe));
    rac_audio_ctl dut (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .ce_i(ce),
        .scl_i(scl), .sda_i(sda), .vcc_good_i(vcc_i), .osc_stopped_i(osc_i), .sda_o(),
        .sda_oe_o(s_oe), .mfp_o(), .mfp_oe_o(mo), .audio_on_o(ao), .tone_insert_o(ti),
        .tone_512_o(t5), .gain_code_o(gc), .gain_db_o(gd), .osc_disable_o(od),
        .update_freeze_o(hf), .freq_test_o(ft), .osc_fail_o(of), .charge_path_o(cp),
        .diode_bypass_o(db));
    ////////////////////////////////////////
    task automatic chk(input logic [20:0] g, e);
        n_tests++;
        if (g !== e) begin
            fail_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic rchk(input logic [7:0] p, e);
        host.rd(p, q);
        chk({13'h0, q}, {13'h0, e});
    endtask
    task automatic wchk(input logic [7:0] p, d);
        host.wr(`RAC_DEV_ADDR, p, d, a);
        chk({18'h0, a}, 21'h7);
    endtask
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // Supply drop then return: one power-up event
    task automatic pwr();
        vcc_i = 1'b0;
        repeat (4) @(negedge sys_clk_i);
        vcc_i = 1'b1;
        repeat (6) @(negedge sys_clk_i);
    endtask
    ////////////////////////////////////////
    initial begin
        #2ms;
        fail_count++;
        close_out();
    end
    initial begin
        repeat (10) @(negedge sys_clk_i);
        reset_n_i = 1'b1;
        pwr();
        chk(st, {10'h124, 4'h0, 7'h5F});
        rchk(8'h07, 8'h80);
        rchk(8'h08, 8'h50);
        rchk(8'h09, 8'h0A);
        rchk(8'h0A, 8'h44);
        for (int c = 0; c < 16; c++) begin
            wchk(8'h08, 8'h40 | 8'(c));
            chk(st, {10'h125, 4'(c), 7'(3 * c - 33)});
        end
        wchk(8'h08, 8'h7B);
        chk(st, {10'h126, 4'hB, 7'h00});
        wchk(8'h08, 8'h2B);
        chk(st, {10'h123, 4'hB, 7'h00});
        wchk(8'h07, 8'h75);
        wchk(8'h09, 8'h75);
        wchk(8'h0A, 8'h80);
        chk(st, {10'h2DB, 4'hB, 7'h00});
        pwr();
        chk(st, {10'h380, 4'hB, 7'h00});
        rchk(8'h07, 8'h35);
        rchk(8'h08, 8'h1B);
        rchk(8'h09, 8'h2A);
        rchk(8'h0A, 8'hC0);
        osc_i = 1'b1;
        repeat (5) @(negedge sys_clk_i);
        osc_i = 1'b0;
        rchk(8'h0A, 8'hC4);
        host.wr(`RAC_DEV_ADDR ^ 7'h01, 8'h08, 8'h00, a);
        chk({18'h0, a}, 21'h0);
        // Enable low freezes the slave: no ACK, register untouched
        ce = 1'b0;
        host.wr(`RAC_DEV_ADDR, 8'h08, 8'h00, a);
        ce = 1'b1;
        chk({18'h0, a}, 21'h0);
        rchk(8'h08, 8'h1B);
        rchk(8'h20, 8'h00);
        close_out();
    end
endmodule
